// File: rtl/fpsl_regs.vh
`ifndef FPSL_REGS_VH
`define FPSL_REGS_VH

// Register port geometry
`define FPSL_ADDR_W 4
`define FPSL_DATA_W 32

// Register byte offsets
`define FPSL_OFS_CTRL 4'h0
`define FPSL_OFS_STATUS 4'h4
`define FPSL_OFS_COND 4'h8

// Control register fields
`define FPSL_CTRL_W 2
`define FPSL_CTRL_TEST 0
`define FPSL_CTRL_BLANK 1
`define FPSL_CTRL_RST 2'h0

// Status register field positions
`define FPSL_ST_CODE_LO 16
`define FPSL_ST_STATE_LO 20

// Lamp vector bit positions
`define FPSL_LAMP_N 13
`define FPSL_L_ACTIVE 0
`define FPSL_L_READY 1
`define FPSL_L_FAULT 2
`define FPSL_L_RUN 3
`define FPSL_L_COLL 4
`define FPSL_L_LINK 5
`define FPSL_L_TX 6
`define FPSL_L_RX 7
`define FPSL_L_BOOT 8
`define FPSL_L_LOW 9
`define FPSL_L_HIGH 10
`define FPSL_L_FDX 11
`define FPSL_L_CRASH 12
`define FPSL_LAMPS_OFF 13'h0000
`define FPSL_LAMPS_ON 13'h1FFF

// Condition vector width
`define FPSL_COND_N 17

// Run lamp diagnostic codes, value equals flash count
`define FPSL_CODE_W 4
`define FPSL_CODE_NONE 4'h0
`define FPSL_CODE_NO_LINK 4'h3
`define FPSL_CODE_DUP_ADDR 4'h4
`define FPSL_CODE_NO_ADDR 4'h5
`define FPSL_CODE_DEF_ADDR 4'h6
`define FPSL_CODE_NO_EXEC 4'h7
`define FPSL_CODE_BAD_CFG 4'h8
`define FPSL_CODE_STEP 4'h1

// Timing, clock rate in Hz and phase lengths in ms
`define FPSL_CNT_W 32
`define FPSL_ONE 32'h0000_0001
`define FPSL_CNT_ZERO 32'h0000_0000
`define FPSL_CLK_HZ 32'h05F5_E100
`define FPSL_MS_PER_S 32'h0000_03E8
`define FPSL_RUN_FLASH_MS 32'h0000_00C8
`define FPSL_RUN_PAUSE_MS 32'h0000_05DC
`define FPSL_ACT_FLASH_MS 32'h0000_0032
`define FPSL_DL_FLASH_MS 32'h0000_00FA

`endif

// File: rtl/fpsl_flasher.v
`timescale 1ns/100ps
`include "fpsl_regs.vh"

// Turns a trigger into one visible on/off flash.
// A held trigger repeats the flash, so it also serves as a blinker.
module fpsl_flasher #(
    parameter [31:0] HALF_CYC = `FPSL_ONE
) (
    // Clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // Event or level to show
    input wire trig_i,
    // Lamp drive
    output wire lamp_o
);

    // Busy for one on phase plus one off phase
    reg busy_ff;
    // High during the on phase
    reg lamp_ff;
    // Phase timer
    reg [`FPSL_CNT_W-1:0] tmr_ff;

    // Flash timer; events during a flash are merged into it,
    // the off phase guarantees a dark gap between flashes
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            busy_ff <= 1'b0;
            lamp_ff <= 1'b0;
            tmr_ff <= `FPSL_CNT_ZERO;
        end else if (!busy_ff) begin
            // Idle: start on a trigger
            if (trig_i) begin
                busy_ff <= 1'b1;
                lamp_ff <= 1'b1;
                tmr_ff <= `FPSL_CNT_ZERO;
            end
        end else if (tmr_ff == HALF_CYC - `FPSL_ONE) begin
            // End of a phase
            tmr_ff <= `FPSL_CNT_ZERO;
            if (lamp_ff) begin
                lamp_ff <= 1'b0;
            end else begin
                busy_ff <= 1'b0;
            end
        end else begin
            // Phase running
            tmr_ff <= tmr_ff + `FPSL_ONE;
        end
    end

    assign lamp_o = lamp_ff;

endmodule // fpsl_flasher

// File: rtl/fpsl_top.v
`timescale 1ns/100ps
`include "fpsl_regs.vh"

// Behaviour
// - Active lamp on once backplane configured
// - Ready lamp on while module healthy
// - Fault lamp: crash, duplicate, no link, address request
// - Collision lamp flashes on collisions
// - Link lamp follows link active
// - Transmit lamp flashes on sent frames
// - Receive lamp flashes on received frames
// - Boot lamp steady, flashing in download
// - Low speed lamp only at 10M
// - High speed lamp only at 100M
// - Duplex lamp on in full duplex
// - Crash lamp on while log entry stored
// - Run lamp steady in normal operation
// - Three flashes: no link; one, two unused
// - Four flashes: duplicate address
// - Five flashes: requesting an address
// - Six flashes: default address in use
// - Seven flashes: no executive image
// - Eight flashes: invalid network configuration
module fpsl_top #(
    // Run lamp flash phase, on and off each
    parameter [31:0] RUN_FLASH_CYC = `FPSL_CLK_HZ / `FPSL_MS_PER_S * `FPSL_RUN_FLASH_MS,
    // Dark pause between flash groups
    parameter [31:0] RUN_PAUSE_CYC = `FPSL_CLK_HZ / `FPSL_MS_PER_S * `FPSL_RUN_PAUSE_MS,
    // Activity flash phase
    parameter [31:0] ACT_FLASH_CYC = `FPSL_CLK_HZ / `FPSL_MS_PER_S * `FPSL_ACT_FLASH_MS,
    // Download blink phase
    parameter [31:0] DL_FLASH_CYC = `FPSL_CLK_HZ / `FPSL_MS_PER_S * `FPSL_DL_FLASH_MS
) (
    // Clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // Register port
    input wire [`FPSL_ADDR_W-1:0] reg_addr_i,
    input wire [`FPSL_DATA_W-1:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output wire [`FPSL_DATA_W-1:0] reg_rdata_o,
    // Module state conditions, levels
    input wire bp_config_done_i,
    input wire healthy_i,
    input wire crash_reset_i,
    input wire dup_addr_i,
    input wire link_up_i,
    input wire addr_request_i,
    input wire boot_mode_i,
    input wire download_mode_i,
    input wire speed_100_i,
    input wire full_duplex_i,
    input wire crash_log_present_i,
    input wire no_exec_image_i,
    input wire default_addr_i,
    input wire net_cfg_invalid_i,
    // Medium events, one-cycle pulses
    input wire collision_i,
    input wire tx_frame_i,
    input wire rx_frame_i,
    // Lamp drives, high lights the lamp
    output wire active_lamp_o,
    output wire ready_lamp_o,
    output wire fault_lamp_o,
    output wire run_lamp_o,
    output wire collision_lamp_o,
    output wire link_lamp_o,
    output wire transmit_activity_lamp_o,
    output wire receive_activity_lamp_o,
    output wire boot_mode_lamp_o,
    output wire low_speed_lamp_o,
    output wire high_speed_lamp_o,
    output wire full_duplex_lamp_o,
    output wire crash_record_lamp_o
);

    // Run sequencer states
    localparam [1:0] RS_STEADY = 2'h0;
    localparam [1:0] RS_ON = 2'h1;
    localparam [1:0] RS_OFF = 2'h2;
    localparam [1:0] RS_PAUSE = 2'h3;

    // Control bits: lamp test and blanking
    reg [`FPSL_CTRL_W-1:0] ctrl_ff;
    // Read data, valid one cycle after the strobe
    reg [`FPSL_DATA_W-1:0] rdata_ff;
    reg [`FPSL_DATA_W-1:0] nxt_rdata;
    // Registered lamp drives
    reg [`FPSL_LAMP_N-1:0] lamps_ff;
    reg [`FPSL_LAMP_N-1:0] nxt_lamps;
    reg [`FPSL_LAMP_N-1:0] lamp_raw;
    // Run sequencer
    reg [1:0] rs_state_ff;
    reg [1:0] nxt_rs_state;
    reg [`FPSL_CODE_W-1:0] code_ff;
    reg [`FPSL_CODE_W-1:0] nxt_code;
    reg [`FPSL_CODE_W-1:0] left_ff;
    reg [`FPSL_CODE_W-1:0] nxt_left;
    reg [`FPSL_CNT_W-1:0] tmr_ff;
    reg [`FPSL_CNT_W-1:0] nxt_tmr;
    reg run_ff;
    reg nxt_run;
    // Most urgent pending code
    reg [`FPSL_CODE_W-1:0] want_code;
    // Flasher outputs
    wire coll_flash;
    wire tx_flash;
    wire rx_flash;
    wire dl_flash;
    // Raw conditions for readback
    wire [`FPSL_COND_N-1:0] cond_vec;

    // Collision flasher
    // collision lamp flash
    fpsl_flasher #(
        .HALF_CYC(ACT_FLASH_CYC)
    ) u_coll (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .trig_i(collision_i),
        .lamp_o(coll_flash)
    );

    // Transmit flasher
    // transmit activity flash
    fpsl_flasher #(
        .HALF_CYC(ACT_FLASH_CYC)
    ) u_tx (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .trig_i(tx_frame_i),
        .lamp_o(tx_flash)
    );

    // Receive flasher
    // receive activity flash
    fpsl_flasher #(
        .HALF_CYC(ACT_FLASH_CYC)
    ) u_rx (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .trig_i(rx_frame_i),
        .lamp_o(rx_flash)
    );

    // Download blinker; a held level keeps it repeating
    fpsl_flasher #(
        .HALF_CYC(DL_FLASH_CYC)
    ) u_dl (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .trig_i(download_mode_i),
        .lamp_o(dl_flash)
    );

    // Code priority, highest flash count first
    always @* begin
        if (net_cfg_invalid_i) begin
            want_code = `FPSL_CODE_BAD_CFG;
        end else if (no_exec_image_i) begin
            want_code = `FPSL_CODE_NO_EXEC;
        end else if (default_addr_i) begin
            want_code = `FPSL_CODE_DEF_ADDR;
        end else if (addr_request_i) begin
            want_code = `FPSL_CODE_NO_ADDR;
        end else if (dup_addr_i) begin
            want_code = `FPSL_CODE_DUP_ADDR;
        end else if (!link_up_i) begin
            want_code = `FPSL_CODE_NO_LINK;
        end else begin
            // Codes one and two are never produced
            want_code = `FPSL_CODE_NONE;
        end
    end

    // Run sequencer next state
    always @* begin
        nxt_rs_state = rs_state_ff;
        nxt_code = code_ff;
        nxt_left = left_ff;
        nxt_tmr = tmr_ff + `FPSL_ONE;
        nxt_run = run_ff;
        case (rs_state_ff)
            RS_STEADY: begin
                nxt_run = 1'b1;
                nxt_tmr = `FPSL_CNT_ZERO;
                // A dark pause first, so the first flash is visible
                if (want_code != `FPSL_CODE_NONE) begin
                    nxt_rs_state = RS_PAUSE;
                    nxt_run = 1'b0;
                end
            end
            RS_ON: begin
                if (tmr_ff == RUN_FLASH_CYC - `FPSL_ONE) begin
                    nxt_rs_state = RS_OFF;
                    nxt_run = 1'b0;
                    nxt_tmr = `FPSL_CNT_ZERO;
                    nxt_left = left_ff - `FPSL_CODE_STEP;
                end
            end
            RS_OFF: begin
                if (tmr_ff == RUN_FLASH_CYC - `FPSL_ONE) begin
                    nxt_tmr = `FPSL_CNT_ZERO;
                    if (left_ff != `FPSL_CODE_NONE) begin
                        nxt_rs_state = RS_ON;
                        nxt_run = 1'b1;
                    end else begin
                        nxt_rs_state = RS_PAUSE;
                    end
                end
            end
            RS_PAUSE: begin
                if (tmr_ff == RUN_PAUSE_CYC - `FPSL_ONE) begin
                    nxt_tmr = `FPSL_CNT_ZERO;
                    nxt_code = want_code;
                    nxt_left = want_code;
                    if (want_code != `FPSL_CODE_NONE) begin
                        nxt_rs_state = RS_ON;
                    end else begin
                        nxt_rs_state = RS_STEADY;
                    end
                    nxt_run = 1'b1;
                end
            end
            default: begin
                // Unreachable encodings fall back to steady
                nxt_rs_state = RS_STEADY;
                nxt_code = `FPSL_CODE_NONE;
                nxt_run = 1'b1;
                nxt_tmr = `FPSL_CNT_ZERO;
            end
        endcase
    end

    // Run sequencer registers; lamp dark during reset
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rs_state_ff <= RS_STEADY;
            code_ff <= `FPSL_CODE_NONE;
            left_ff <= `FPSL_CODE_NONE;
            tmr_ff <= `FPSL_CNT_ZERO;
            run_ff <= 1'b0;
        end else begin
            rs_state_ff <= nxt_rs_state;
            code_ff <= nxt_code;
            left_ff <= nxt_left;
            tmr_ff <= nxt_tmr;
            run_ff <= nxt_run;
        end
    end

    // Lamp functions before test and blanking
    always @* begin
        lamp_raw = `FPSL_LAMPS_OFF;
        lamp_raw[`FPSL_L_ACTIVE] = bp_config_done_i;
        lamp_raw[`FPSL_L_READY] = healthy_i;
        lamp_raw[`FPSL_L_FAULT] = crash_reset_i | dup_addr_i | ~link_up_i | addr_request_i;
        lamp_raw[`FPSL_L_RUN] = run_ff;
        lamp_raw[`FPSL_L_COLL] = coll_flash;
        lamp_raw[`FPSL_L_LINK] = link_up_i;
        lamp_raw[`FPSL_L_TX] = tx_flash;
        lamp_raw[`FPSL_L_RX] = rx_flash;
        lamp_raw[`FPSL_L_BOOT] = download_mode_i ? dl_flash : boot_mode_i;
        // only with a link at low speed
        lamp_raw[`FPSL_L_LOW] = link_up_i & ~speed_100_i;
        // only with a link at high speed
        lamp_raw[`FPSL_L_HIGH] = link_up_i & speed_100_i;
        lamp_raw[`FPSL_L_FDX] = full_duplex_i;
        lamp_raw[`FPSL_L_CRASH] = crash_log_present_i;
    end

    // Lamp test overrides blanking so a dark panel can be checked
    always @* begin
        if (ctrl_ff[`FPSL_CTRL_TEST]) begin
            nxt_lamps = `FPSL_LAMPS_ON;
        end else if (ctrl_ff[`FPSL_CTRL_BLANK]) begin
            nxt_lamps = `FPSL_LAMPS_OFF;
        end else begin
            nxt_lamps = lamp_raw;
        end
    end

    // Lamp drive registers
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lamps_ff <= `FPSL_LAMPS_OFF;
        end else begin
            lamps_ff <= nxt_lamps;
        end
    end

    // Condition snapshot for software
    assign cond_vec = {net_cfg_invalid_i, default_addr_i, no_exec_image_i,
        crash_log_present_i, full_duplex_i, speed_100_i, download_mode_i,
        boot_mode_i, rx_frame_i, tx_frame_i, collision_i, addr_request_i,
        link_up_i, dup_addr_i, crash_reset_i, healthy_i, bp_config_done_i};

    // Control register write; other offsets ignore writes
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_ff <= `FPSL_CTRL_RST;
        end else if (reg_wr_i && reg_addr_i == `FPSL_OFS_CTRL) begin
            ctrl_ff <= reg_wdata_i[`FPSL_CTRL_W-1:0];
        end
    end

    // Read mux; zero outside the read cycle and for unmapped offsets
    always @* begin
        nxt_rdata = {`FPSL_DATA_W{1'b0}};
        if (reg_rd_i) begin
            case (reg_addr_i)
                `FPSL_OFS_CTRL: begin
                    nxt_rdata[`FPSL_CTRL_W-1:0] = ctrl_ff;
                end
                `FPSL_OFS_STATUS: begin
                    // Shown lamps, active code and sequencer state
                    nxt_rdata[`FPSL_LAMP_N-1:0] = lamps_ff;
                    nxt_rdata[`FPSL_ST_CODE_LO +: `FPSL_CODE_W] = code_ff;
                    nxt_rdata[`FPSL_ST_STATE_LO +: 2] = rs_state_ff;
                end
                `FPSL_OFS_COND: begin
                    nxt_rdata[`FPSL_COND_N-1:0] = cond_vec;
                end
                default: begin
                    nxt_rdata = {`FPSL_DATA_W{1'b0}};
                end
            endcase
        end
    end

    // Read data register
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_ff <= {`FPSL_DATA_W{1'b0}};
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Outputs straight from registers
    assign reg_rdata_o = rdata_ff;
    assign active_lamp_o = lamps_ff[`FPSL_L_ACTIVE];
    assign ready_lamp_o = lamps_ff[`FPSL_L_READY];
    assign fault_lamp_o = lamps_ff[`FPSL_L_FAULT];
    assign run_lamp_o = lamps_ff[`FPSL_L_RUN];
    assign collision_lamp_o = lamps_ff[`FPSL_L_COLL];
    assign link_lamp_o = lamps_ff[`FPSL_L_LINK];
    assign transmit_activity_lamp_o = lamps_ff[`FPSL_L_TX];
    assign receive_activity_lamp_o = lamps_ff[`FPSL_L_RX];
    assign boot_mode_lamp_o = lamps_ff[`FPSL_L_BOOT];
    assign low_speed_lamp_o = lamps_ff[`FPSL_L_LOW];
    assign high_speed_lamp_o = lamps_ff[`FPSL_L_HIGH];
    assign full_duplex_lamp_o = lamps_ff[`FPSL_L_FDX];
    assign crash_record_lamp_o = lamps_ff[`FPSL_L_CRASH];

endmodule // fpsl_top

// File: testbench/fpsl_monitor.sv
`timescale 1ns/100ps
`include "fpsl_regs.vh"
// Lamp checker, sees only the top ports
module fpsl_monitor #(
    parameter [31:0] RUN_FLASH_CYC = 32'h0000_0004,
    parameter [31:0] RUN_PAUSE_CYC = 32'h0000_000C,
    parameter [31:0] ACT_FLASH_CYC = 32'h0000_0003
) (
    // Clock, reset and register port
    input wire clk_i, sys_rst_i, reg_wr_i, reg_rd_i,
    input wire [3:0] reg_addr_i,
    input wire [31:0] reg_wdata_i, reg_rdata_o,
    // Conditions
    input wire bp_config_done_i, healthy_i, crash_reset_i, dup_addr_i, link_up_i,
    input wire addr_request_i, boot_mode_i, download_mode_i, speed_100_i, full_duplex_i,
    input wire crash_log_present_i, collision_i, tx_frame_i, rx_frame_i,
    // Lamps
    input wire active_lamp_o, ready_lamp_o, fault_lamp_o, run_lamp_o, collision_lamp_o,
    input wire link_lamp_o, transmit_activity_lamp_o, receive_activity_lamp_o,
    input wire boot_mode_lamp_o, low_speed_lamp_o, high_speed_lamp_o,
    input wire full_duplex_lamp_o, crash_record_lamp_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic live_ff; // Out of reset for a full edge
    logic [1:0] ctl_ff; // Shadow of lamp test and blank
    logic [1:0] ovr_ff; // Override still draining out
    logic [31:0] con_ff; // Collision lamp lit run
    logic [31:0] don_ff; // Run lamp dark run
    logic seen_ff; // First run lamp rise after reset is not a gap
    // Override lingers two edges, so lamp checks stay quiet meanwhile
    wire quiet = live_ff && ctl_ff == 2'h0 && ovr_ff == 2'h0;
    // Helper counters and shadows
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            live_ff <= 1'b0;
            ctl_ff <= 2'h0;
            ovr_ff <= 2'h0;
            con_ff <= 32'h0000_0000;
            don_ff <= 32'h0000_0000;
            seen_ff <= 1'b0;
        end else begin
            live_ff <= 1'b1;
            if (reg_wr_i && reg_addr_i == `FPSL_OFS_CTRL) begin
                ctl_ff <= reg_wdata_i[1:0];
            end
            ovr_ff <= {ovr_ff[0], |ctl_ff};
            con_ff <= collision_lamp_o ? con_ff + 32'h0000_0001 : 32'h0000_0000;
            don_ff <= run_lamp_o ? 32'h0000_0000 : don_ff + 32'h0000_0001;
            seen_ff <= seen_ff | run_lamp_o;
        end
    end
    sequence coll_end_s;
        quiet && $fell(collision_lamp_o);
    endsequence
    sequence run_rise_s;
        quiet && seen_ff && $rose(run_lamp_o);
    endsequence
    plain_lamps_a : assert property (
        quiet |-> {active_lamp_o, ready_lamp_o, link_lamp_o, full_duplex_lamp_o,
        crash_record_lamp_o} == $past({bp_config_done_i, healthy_i, link_up_i,
        full_duplex_i, crash_log_present_i})) else $error("plain lamp wrong");
    fault_lamp_a : assert property (
        quiet |-> fault_lamp_o == $past(crash_reset_i | dup_addr_i | !link_up_i |
        addr_request_i)) else $error("fault lamp wrong");
    speed_lamps_a : assert property (
        quiet |-> {low_speed_lamp_o, high_speed_lamp_o} == $past({link_up_i & ~speed_100_i,
        link_up_i & speed_100_i})) else $error("speed lamp wrong");
    boot_steady_a : assert property (
        quiet && !$past(download_mode_i) |-> boot_mode_lamp_o == $past(boot_mode_i))
        else $error("boot lamp wrong");
    coll_start_a : assert property (
        quiet && $rose(collision_lamp_o) |-> $past(collision_i, 2))
        else $error("collision flash without cause");
    coll_length_a : assert property (
        coll_end_s |-> con_ff == ACT_FLASH_CYC) else $error("collision flash length");
    act_start_a : assert property (
        quiet |-> (!$rose(transmit_activity_lamp_o) || $past(tx_frame_i, 2)) &&
        (!$rose(receive_activity_lamp_o) || $past(rx_frame_i, 2)))
        else $error("activity flash without cause");
    run_gap_a : assert property (
        run_rise_s |-> don_ff == RUN_FLASH_CYC || don_ff == RUN_PAUSE_CYC ||
        don_ff == RUN_FLASH_CYC + RUN_PAUSE_CYC) else $error("run lamp dark gap length");
    read_idle_a : assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000) else $error("stray read data");
    lamp_test_a : assert property (
        live_ff && $past(ctl_ff[0]) |-> {active_lamp_o, ready_lamp_o, fault_lamp_o,
        run_lamp_o, collision_lamp_o, link_lamp_o, transmit_activity_lamp_o,
        receive_activity_lamp_o, boot_mode_lamp_o, low_speed_lamp_o, high_speed_lamp_o,
        full_duplex_lamp_o, crash_record_lamp_o} == `FPSL_LAMPS_ON)
        else $error("lamp test not all on");
endmodule // fpsl_monitor

bind fpsl_top fpsl_monitor fpsl_monitor_inst (.*);

// File: testbench/fpsl_viewer.sv
`timescale 1ns/100ps
// Operator's eye on the run lamp: counts flashes per group.
// Dark longer than GAP_CYC closes a group, lit that long means steady.
module fpsl_viewer #(
    parameter [31:0] GAP_CYC = 32'h0000_0008
) (
    // Clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // Lamp seen
    input wire run_lamp_i,
    // One group seen
    output reg grp_done_o,
    output reg [3:0] grp_cnt_o
);
    reg lamp_ff; // Last lamp level
    reg [3:0] cnt_ff; // Flashes so far
    reg [31:0] dark_ff; // Dark run length
    reg [31:0] lit_ff; // Lit run length
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lamp_ff <= 1'b0;
            cnt_ff <= 4'h0;
            dark_ff <= 32'h0000_0000;
            lit_ff <= 32'h0000_0000;
            grp_done_o <= 1'b0;
            grp_cnt_o <= 4'h0;
        end else begin
            lamp_ff <= run_lamp_i;
            grp_done_o <= 1'b0;
            dark_ff <= run_lamp_i ? 32'h0000_0000 : dark_ff + 32'h0000_0001;
            lit_ff <= run_lamp_i ? lit_ff + 32'h0000_0001 : 32'h0000_0000;
            if (run_lamp_i && !lamp_ff) begin
                cnt_ff <= cnt_ff + 4'h1;
            end
            // Steady light is no flash
            if (lit_ff == GAP_CYC) begin
                cnt_ff <= 4'h0;
            end
            if (dark_ff == GAP_CYC && cnt_ff != 4'h0) begin
                grp_done_o <= 1'b1;
                grp_cnt_o <= cnt_ff;
                cnt_ff <= 4'h0;
            end
        end
    end
endmodule // fpsl_viewer

// File: testbench/fpsl_top_tb.sv
`timescale 1ns/100ps
`include "fpsl_regs.vh"
// Bench for the front panel lamps
module fpsl_top_tb;
    // Condition vectors for codes 8 down to 3, same layout as COND
    localparam [101:0] VT = {17'h1_0010, 17'h0_4010, 17'h0_8010, 17'h0_0030, 17'h0_0018,
        17'h0_0000};
    reg clk_i, sys_rst_i, reg_wr_i, reg_rd_i, rd_q, gw, pv;
    reg [3:0] reg_addr_i, g;
    reg [31:0] reg_wdata_i, seed, tmo;
    reg [16:0] cv; // All conditions, COND bit order
    reg [63:0] e;
    wire [31:0] reg_rdata_o;
    wire [12:0] lamp; // STATUS bit order
    wire grp_done;
    wire [3:0] grp_cnt;
    integer err_count, checked, i, k, n;
    reg [63:0] exp_q[$]; // Read notes: mask, value
    reg [3:0] grp_q[$]; // Flash group notes

    fpsl_top #(.RUN_FLASH_CYC(32'h0000_0004), .RUN_PAUSE_CYC(32'h0000_000C),
        .ACT_FLASH_CYC(32'h0000_0003), .DL_FLASH_CYC(32'h0000_0005)) fpsl_top_inst (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .bp_config_done_i(cv[0]), .healthy_i(cv[1]),
        .crash_reset_i(cv[2]), .dup_addr_i(cv[3]), .link_up_i(cv[4]),
        .addr_request_i(cv[5]), .collision_i(cv[6]), .tx_frame_i(cv[7]),
        .rx_frame_i(cv[8]), .boot_mode_i(cv[9]), .download_mode_i(cv[10]),
        .speed_100_i(cv[11]), .full_duplex_i(cv[12]), .crash_log_present_i(cv[13]),
        .no_exec_image_i(cv[14]), .default_addr_i(cv[15]), .net_cfg_invalid_i(cv[16]),
        .active_lamp_o(lamp[0]), .ready_lamp_o(lamp[1]), .fault_lamp_o(lamp[2]),
        .run_lamp_o(lamp[3]), .collision_lamp_o(lamp[4]), .link_lamp_o(lamp[5]),
        .transmit_activity_lamp_o(lamp[6]), .receive_activity_lamp_o(lamp[7]),
        .boot_mode_lamp_o(lamp[8]), .low_speed_lamp_o(lamp[9]),
        .high_speed_lamp_o(lamp[10]), .full_duplex_lamp_o(lamp[11]),
        .crash_record_lamp_o(lamp[12]));
    fpsl_viewer fpsl_viewer_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .run_lamp_i(lamp[3]),
        .grp_done_o(grp_done), .grp_cnt_o(grp_cnt));

    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Static lamps expected from conditions, download off
    function [31:0] exp_lamps(input [16:0] c);
        exp_lamps = {19'h0, c[13], c[12], c[4] & c[11], c[4] & !c[11], c[9], 2'h0, c[4],
            2'h0, c[2] | c[3] | !c[4] | c[5], c[1], c[0]};
    endfunction
    task chk(input [31:0] got, input [31:0] want);
        checked = checked + 1;
        if (got !== want) begin
            err_count = err_count + 1;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Bus cycles, a free edge after each strobe
    task wr(input [3:0] a, input [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task rd(input [3:0] a, input [31:0] m, input [31:0] v);
        exp_q.push_back({m, v});
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task drain;
        k = 0;
        while (grp_q.size() != 0 && k < 600) begin
            @(posedge clk_i);
            k = k + 1;
        end
    endtask
    task wl(input v);
        k = 0;
        while (lamp[3] !== v && k < 100) begin
            @(posedge clk_i);
            k = k + 1;
        end
    endtask
    // Steady first, then one condition, one group expected
    task show(input [16:0] v, input [3:0] c);
        cv <= 17'h0_0010;
        repeat (100) @(posedge clk_i);
        rd(4'h4, 32'h003F_0008, 32'h0000_0008);
        grp_q.push_back(c);
        cv <= v;
        drain;
        cv <= 17'h0_0010;
        rd(4'h4, 32'h000F_0000, {12'h0, c, 16'h0});
    endtask

    // Clock, 100 MHz
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Watcher: read data and flash groups against the oldest note
    always @(posedge clk_i) begin
        if (rd_q) begin
            e = exp_q.pop_front();
            chk(reg_rdata_o & e[63:32], e[31:0]);
        end
        if (grp_done && gw) begin
            g = grp_q.size() != 0 ? grp_q.pop_front() : 4'hF;
            chk({28'h0, grp_cnt}, {28'h0, g});
        end
        rd_q <= reg_rd_i;
        tmo <= tmo + 32'h0000_0001;
        if (tmo == 32'h0000_1F40) begin
            err_count = err_count + 1;
            give_verdict;
        end
    end
    initial begin
        sys_rst_i = 1'b1;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 4'h0;
        reg_wdata_i = 32'h0000_0000;
        cv = 17'h0_0010;
        rd_q = 1'b0;
        gw = 1'b0;
        pv = 1'b0;
        tmo = 32'h0000_0000;
        seed = 32'h0000_2069;
        err_count = 0;
        checked = 0;
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        // Random conditions, download held off
        for (i = 0; i < 24; i = i + 1) begin
            seed = lfsr(seed);
            cv <= seed[16:0] & 17'h1_FBFF;
            repeat (3) @(posedge clk_i);
            rd(4'h4, 32'h0000_1F27, exp_lamps(cv));
            rd(4'h8, 32'h0001_FFFF, {15'h0, cv});
        end
        cv <= 17'h0_0010;
        repeat (120) @(posedge clk_i);
        gw = 1'b1;
        for (i = 3; i < 9; i = i + 1) begin
            show(VT[(i - 3) * 17 +: 17], i[3:0]);
        end
        show(17'h1_0018, 4'h8);
        // Higher code arrives mid group: group of three still finishes
        repeat (100) @(posedge clk_i);
        grp_q.push_back(4'h3);
        grp_q.push_back(4'h8);
        cv <= 17'h0_0000;
        wl(1'b0);
        wl(1'b1);
        cv <= 17'h1_0000;
        drain;
        cv <= 17'h0_0010;
        chk(grp_q.size(), 32'h0000_0000);
        // Download blinks the boot lamp
        cv <= 17'h0_0610;
        n = 0;
        repeat (60) begin
            @(posedge clk_i);
            if (lamp[8] && !pv) n = n + 1;
            pv = lamp[8];
        end
        chk({31'h0, n >= 4}, 32'h0000_0001);
        cv <= 17'h0_0010;
        repeat (100) @(posedge clk_i);
        // Lamp test, blank, unmapped place
        wr(4'h0, 32'h0000_0001);
        rd(4'h4, 32'h0000_1FFF, 32'h0000_1FFF);
        wr(4'h0, 32'h0000_0002);
        rd(4'h4, 32'h0000_1FFF, 32'h0000_0000);
        rd(4'h0, 32'hFFFF_FFFF, 32'h0000_0002);
        wr(4'hC, 32'h0000_0003);
        rd(4'hC, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(4'h0, 32'h0000_0001);
        // Reset mid run clears control
        sys_rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        rd(4'h0, 32'hFFFF_FFFF, 32'h0000_0000);
        repeat (20) @(posedge clk_i);
        rd(4'h4, 32'h003F_0008, 32'h0000_0008);
        repeat (4) @(posedge clk_i);
        give_verdict;
    end
endmodule // fpsl_top_tb
